//--- hw/ucpmc_pkg.sv
// Shared constants for the USB charge-port mode controller.
// Assumes a single 100 MHz core clock; no other context needed.
package ucpmc_pkg;

   // Mode-select codes {bit one, bit two, bit three}
   localparam logic [2:0] SEL_OFF      = 3'h0;
   localparam logic [2:0] SEL_SDP      = 3'h6;
   localparam logic [2:0] SEL_CDP      = 3'h7;
   localparam logic [2:0] SEL_SDP_WAKE = 3'h2;
   localparam logic [2:0] SEL_CDP_WAKE = 3'h3;
   localparam logic [2:0] SEL_DCP_AUTO = 3'h1;
   localparam logic [2:0] SEL_DCP_DIV  = 3'h5;
   localparam logic [2:0] SEL_DCP_BC12 = 3'h4;

   // Port profile presented to the analog side
   typedef enum logic [4:0] {
      PROF_OFF  = 5'h01,
      PROF_SDP  = 5'h02,
      PROF_CDP  = 5'h04,
      PROF_DIV  = 5'h08,
      PROF_BC12 = 5'h10
   } ucpmc_profile_type;

   // Dedicated-charging auto-detect states
   typedef enum logic [3:0] {
      AUTO_DIV   = 4'h1,
      AUTO_PULSE = 4'h2,
      AUTO_BC12  = 4'h4,
      AUTO_WAIT  = 4'h8
   } ucpmc_auto_type;

   // Timing
   localparam int unsigned CLK_KHZ          = 100000;
   localparam int unsigned PULSE_TIME_MS    = 350;
   localparam int unsigned DETACH_TIME_S    = 10;
   localparam int unsigned CHG_OFF_TIME_S   = 5;
   localparam int unsigned PULSE_CYCLES     = PULSE_TIME_MS * CLK_KHZ;
   localparam int unsigned DETACH_CYCLES    = DETACH_TIME_S * 1000 * CLK_KHZ;
   localparam int unsigned CHG_OFF_CYCLES   = CHG_OFF_TIME_S * 1000 * CLK_KHZ;

   // Register map (byte addresses)
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam int CTRL_SOFT_OFF   = 0;
   localparam int STAT_PROF_LSB   = 0;
   localparam int STAT_DISCHARGE  = 5;
   localparam int STAT_POWER      = 6;
   localparam int STAT_DATA       = 7;
   localparam int STAT_DETECT     = 8;
   localparam int STAT_CHARGING   = 9;
   localparam int STAT_SEL_LSB    = 10;
   localparam int STAT_PIN_LEVEL  = 13;
   localparam logic CTRL_SOFT_OFF_RESET = 1'h0;

   // Synchroniser vector layout
   localparam int SYNC_WIDTH = 10;
   localparam int SY_EN  = 9;
   localparam int SY_B1  = 8;
   localparam int SY_B2  = 7;
   localparam int SY_B3  = 6;
   localparam int SY_NEG = 5;
   localparam int SY_ATT = 4;
   localparam int SY_FHS = 3;
   localparam int SY_CUR = 2;
   localparam int SY_HS  = 1;
   localparam int SY_PIN = 0;

endpackage : ucpmc_pkg

//--- hw/ucpmc_sync.sv
// Two-flop synchroniser for a vector of unrelated level inputs.
// Assumes each bit is an independent level; no bus coherency is given.
`timescale 1ns/100ps
module ucpmc_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // Levels
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         stage1_reg <= '0;
         syncOut    <= '0;
      end else begin
         stage1_reg <= asyncIn;
         syncOut    <= stage1_reg;
      end
   end

endmodule : ucpmc_sync

//--- hw/ucpmc_timer.sv
// One-shot down counter: active for CYCLES clocks after a start.
// Assumes start and abort come from logic on the same clock.
`timescale 1ns/100ps
module ucpmc_timer #(
   parameter logic [31:0] CYCLES = 32'h0000_0001
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // Control
   input  wire logic startPulse,
   input  wire logic abortPulse,
   // Status
   output logic      timerActive,
   output logic      expirePulse
);

   logic [31:0] count_reg;

   // Start wins over abort so a restart is never lost
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         count_reg <= 32'h0000_0000;
      end else if (startPulse) begin
         count_reg <= CYCLES;
      end else if (abortPulse) begin
         count_reg <= 32'h0000_0000;
      end else if (count_reg != 32'h0000_0000) begin
         count_reg <= count_reg - 32'h0000_0001;
      end
   end

   assign timerActive = (count_reg != 32'h0000_0000);
   assign expirePulse = (count_reg == 32'h0000_0001) && !startPulse && !abortPulse;

endmodule : ucpmc_timer

//--- hw/ucpmc_top.sv
// Mode controller of a USB charge port: select decode, discharge pulse,
// auto-detect sequencing and charge indication, with a Wishbone slave.
// Assumes analog detectors deliver levels asynchronous to core_clk.
// Summary of operation
// - Select 000: port off, discharge active.
// - Select 110: standard port, data on.
// - Select 111: charging downstream port with detection.
// - Select 010: standard port, wakeup for all.
// - Select 011: charging port, low-speed wakeup, else auto.
// - Select 001: dedicated-charging auto-detect with detection.
// - Select 101: forced divider dedicated charging.
// - Select 100: forced BC1.2 dedicated charging.
// - Auto starts divider; negotiation gives pulse, BC1.2.
// - BC1.2 detach: back to divider after 10 s.
// - In 011 go auto on fast attach/detach.
// - 110 and 010 swap: no pulse, data on.
// - x10/111 with 011 swap: no pulse, data on.
// - Any other mode change: 350 ms discharge pulse.
// - Enable low or select 000: permanent discharge.
// - Steady standard/charging levels: no automatic auto mode.
// - Charging modes: indicator while current above threshold.
// - Charging downstream: indicator only after prior handshake.
// - Indicator released after 5 s below threshold.
// - Enable low: switches, profiles off, indicator released.
`timescale 1ns/100ps
module ucpmc_top #(
   parameter logic [31:0] PULSE_CYCLES   = 32'(ucpmc_pkg::PULSE_CYCLES),
   parameter logic [31:0] DETACH_CYCLES  = 32'(ucpmc_pkg::DETACH_CYCLES),
   parameter logic [31:0] CHG_OFF_CYCLES = 32'(ucpmc_pkg::CHG_OFF_CYCLES)
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Host control pins
   input  wire logic        enable,
   input  wire logic        mode_select_bit_one,
   input  wire logic        mode_select_bit_two,
   input  wire logic        mode_select_bit_three,
   // Port detectors
   input  wire logic        chargeNegotiation,
   input  wire logic        deviceAttached,
   input  wire logic        deviceFullHighSpeed,
   input  wire logic        currentAboveThreshold,
   input  wire logic        cdpHandshakeDone,
   // Port controls
   output ucpmc_pkg::ucpmc_profile_type portProfile,
   output logic             powerSwitchOn,
   output logic             dataSwitchOn,
   output logic             dischargeOn,
   output logic             chargeDetectOn,
   // Charge indicator, open drain, active low
   input  wire logic        chargeInd_nIn,
   output logic             chargeInd_nOut,
   output logic             chargeInd_nOe
);

   logic [ucpmc_pkg::SYNC_WIDTH-1:0] syncVec;
   logic [2:0]  selNow;
   logic [2:0]  prevSel_reg;
   logic        softOff_reg;
   logic        enabled;
   logic        selChange;
   logic        skipPulse;
   logic        pulseStart;
   logic        pulseActive;
   logic        pulseExpire;
   logic        autoMode;
   logic        autoPulseReq;
   logic        attachedPrev_reg;
   logic        attachedRose;
   logic        attachedFell;
   logic        cdpAuto_reg;
   logic        detachStart;
   logic        detachAbort;
   logic        detachExpire;
   logic        abovePrev_reg;
   logic        currentRose;
   logic        currentFell;
   logic        handshakeSeen_reg;
   logic        allowed_reg;
   logic        allowedNow;
   logic        chargeMode;
   logic        indicator_reg;
   logic        offStart;
   logic        offAbort;
   logic        offExpire;
   logic        wbReq;
   ucpmc_pkg::ucpmc_auto_type    autoState_reg;
   ucpmc_pkg::ucpmc_profile_type profileNext;
   logic        powerNext;
   logic        dataNext;
   logic        dischargeNext;
   logic        detectNext;

   // Every pin passes two flops before decode
   ucpmc_sync #(
      .WIDTH(ucpmc_pkg::SYNC_WIDTH)
   ) pinSync (
      .core_clk(core_clk),
      .reset_n (reset_n),
      .asyncIn ({enable, mode_select_bit_one, mode_select_bit_two, mode_select_bit_three,
                 chargeNegotiation, deviceAttached, deviceFullHighSpeed,
                 currentAboveThreshold, cdpHandshakeDone, chargeInd_nIn}),
      .syncOut (syncVec)
   );

   assign selNow  = {syncVec[ucpmc_pkg::SY_B1], syncVec[ucpmc_pkg::SY_B2], syncVec[ucpmc_pkg::SY_B3]};
   assign enabled = syncVec[ucpmc_pkg::SY_EN] && !softOff_reg;

   function automatic logic isX10(input logic [2:0] s);
      isX10 = (s == ucpmc_pkg::SEL_SDP) || (s == ucpmc_pkg::SEL_SDP_WAKE);
   endfunction : isX10

   function automatic logic wakeSide(input logic [2:0] s);
      wakeSide = isX10(s) || (s == ucpmc_pkg::SEL_CDP);
   endfunction : wakeSide

   // A briefly skewed 111 to 001 move would read as an extra change
   assign selChange = enabled && (selNow != prevSel_reg);
   assign skipPulse = (isX10(selNow) && isX10(prevSel_reg))
                    || (selNow == ucpmc_pkg::SEL_CDP_WAKE && wakeSide(prevSel_reg))
                    || (prevSel_reg == ucpmc_pkg::SEL_CDP_WAKE && wakeSide(selNow));
   assign autoPulseReq = autoMode && (autoState_reg == ucpmc_pkg::AUTO_DIV)
                       && syncVec[ucpmc_pkg::SY_NEG];
   assign pulseStart = (selChange && !skipPulse && (selNow != ucpmc_pkg::SEL_OFF))
                     || autoPulseReq;

   // Disabled counts as select 000 so re-enabling also pulses
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         prevSel_reg <= ucpmc_pkg::SEL_OFF;
      end else begin
         prevSel_reg <= enabled ? selNow : ucpmc_pkg::SEL_OFF;
      end
   end

   ucpmc_timer #(
      .CYCLES(PULSE_CYCLES)
   ) pulseTimer (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .startPulse (pulseStart),
      .abortPulse (!enabled),
      .timerActive(pulseActive),
      .expirePulse(pulseExpire)
   );

   // Attach and current-threshold edges
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         attachedPrev_reg <= 1'h0;
         abovePrev_reg    <= 1'h0;
      end else begin
         attachedPrev_reg <= syncVec[ucpmc_pkg::SY_ATT];
         abovePrev_reg    <= syncVec[ucpmc_pkg::SY_CUR];
      end
   end

   assign attachedRose = syncVec[ucpmc_pkg::SY_ATT] && !attachedPrev_reg;
   assign attachedFell = !syncVec[ucpmc_pkg::SY_ATT] && attachedPrev_reg;
   assign currentRose  = syncVec[ucpmc_pkg::SY_CUR] && !abovePrev_reg;
   assign currentFell  = !syncVec[ucpmc_pkg::SY_CUR] && abovePrev_reg;

   // Wake mode 011 hands fast or newly detached ports to auto mode
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         cdpAuto_reg <= 1'h0;
      end else if (enabled && selNow == ucpmc_pkg::SEL_CDP_WAKE && attachedFell) begin
         cdpAuto_reg <= 1'h1;
      end else if (enabled && selNow == ucpmc_pkg::SEL_CDP_WAKE && syncVec[ucpmc_pkg::SY_ATT]
                   && syncVec[ucpmc_pkg::SY_FHS]) begin
         cdpAuto_reg <= 1'h1;
      end else if (!enabled || selNow != ucpmc_pkg::SEL_CDP_WAKE) begin
         cdpAuto_reg <= 1'h0;
      end
   end

   assign autoMode = enabled && ((selNow == ucpmc_pkg::SEL_DCP_AUTO)
                   || (selNow == ucpmc_pkg::SEL_CDP_WAKE && cdpAuto_reg));
   assign detachStart = autoMode && (autoState_reg == ucpmc_pkg::AUTO_BC12) && attachedFell;
   assign detachAbort = !autoMode || ((autoState_reg == ucpmc_pkg::AUTO_WAIT) && attachedRose);

   ucpmc_timer #(
      .CYCLES(DETACH_CYCLES)
   ) detachTimer (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .startPulse (detachStart),
      .abortPulse (detachAbort),
      .timerActive(),
      .expirePulse(detachExpire)
   );

   // Auto-detect sequence
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         autoState_reg <= ucpmc_pkg::AUTO_DIV;
      end else if (!autoMode) begin
         autoState_reg <= ucpmc_pkg::AUTO_DIV;
      end else begin
         case (autoState_reg)
            ucpmc_pkg::AUTO_DIV: begin
               if (autoPulseReq) autoState_reg <= ucpmc_pkg::AUTO_PULSE;
            end
            ucpmc_pkg::AUTO_PULSE: begin
               if (pulseExpire) autoState_reg <= ucpmc_pkg::AUTO_BC12;
            end
            ucpmc_pkg::AUTO_BC12: begin
               if (attachedFell) autoState_reg <= ucpmc_pkg::AUTO_WAIT;
            end
            ucpmc_pkg::AUTO_WAIT: begin
               if (attachedRose) begin
                  autoState_reg <= ucpmc_pkg::AUTO_BC12;
               end else if (detachExpire) begin
                  autoState_reg <= ucpmc_pkg::AUTO_DIV;
               end
            end
            default: autoState_reg <= ucpmc_pkg::AUTO_DIV;
         endcase
      end
   end

   // Select decode into port controls
   always_comb begin
      profileNext   = ucpmc_pkg::PROF_OFF;
      powerNext     = 1'h1;
      dataNext      = 1'h0;
      dischargeNext = 1'h0;
      detectNext    = 1'h1;
      if (autoMode) begin
         profileNext = (autoState_reg == ucpmc_pkg::AUTO_DIV) ? ucpmc_pkg::PROF_DIV
                                                              : ucpmc_pkg::PROF_BC12;
      end else begin
         case (selNow)
            ucpmc_pkg::SEL_SDP, ucpmc_pkg::SEL_SDP_WAKE: begin
               profileNext = ucpmc_pkg::PROF_SDP;
               dataNext    = 1'h1;
               detectNext  = 1'h0;
            end
            ucpmc_pkg::SEL_CDP, ucpmc_pkg::SEL_CDP_WAKE: begin
               profileNext = ucpmc_pkg::PROF_CDP;
               dataNext    = 1'h1;
            end
            ucpmc_pkg::SEL_DCP_DIV: profileNext = ucpmc_pkg::PROF_DIV;
            ucpmc_pkg::SEL_DCP_BC12: profileNext = ucpmc_pkg::PROF_BC12;
            default: begin
               profileNext   = ucpmc_pkg::PROF_OFF;
               powerNext     = 1'h0;
               dischargeNext = 1'h1;
               detectNext    = 1'h0;
            end
         endcase
      end
      if (!enabled) begin
         profileNext   = ucpmc_pkg::PROF_OFF;
         powerNext     = 1'h0;
         dataNext      = 1'h0;
         dischargeNext = 1'h1;
         detectNext    = 1'h0;
      end else if (pulseActive || pulseStart) begin
         // Bus is dropped for the pulse so the device restarts its handshake
         powerNext     = 1'h0;
         dataNext      = 1'h0;
         dischargeNext = 1'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         portProfile    <= ucpmc_pkg::PROF_OFF;
         powerSwitchOn  <= 1'h0;
         dataSwitchOn   <= 1'h0;
         dischargeOn    <= 1'h1;
         chargeDetectOn <= 1'h0;
      end else begin
         portProfile    <= profileNext;
         powerSwitchOn  <= powerNext;
         dataSwitchOn   <= dataNext;
         dischargeOn    <= dischargeNext;
         chargeDetectOn <= detectNext;
      end
   end

   // Charge indication
   assign chargeMode = enabled && powerSwitchOn && chargeDetectOn;
   assign allowedNow = currentRose ? ((portProfile != ucpmc_pkg::PROF_CDP) || handshakeSeen_reg)
                                   : allowed_reg;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         handshakeSeen_reg <= 1'h0;
         allowed_reg       <= 1'h0;
      end else begin
         if (portProfile != ucpmc_pkg::PROF_CDP) begin
            handshakeSeen_reg <= 1'h0;
         end else if (syncVec[ucpmc_pkg::SY_HS]) begin
            handshakeSeen_reg <= 1'h1;
         end
         allowed_reg <= allowedNow;
      end
   end

   assign offStart = indicator_reg && currentFell;
   assign offAbort = syncVec[ucpmc_pkg::SY_CUR] || !chargeMode;

   ucpmc_timer #(
      .CYCLES(CHG_OFF_CYCLES)
   ) offTimer (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .startPulse (offStart),
      .abortPulse (offAbort),
      .timerActive(),
      .expirePulse(offExpire)
   );

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         indicator_reg <= 1'h0;
      end else if (!chargeMode) begin
         indicator_reg <= 1'h0;
      end else if (syncVec[ucpmc_pkg::SY_CUR] && allowedNow) begin
         indicator_reg <= 1'h1;
      end else if (offExpire) begin
         indicator_reg <= 1'h0;
      end
   end

   assign chargeInd_nOut = 1'h0;
   assign chargeInd_nOe  = indicator_reg;

   // Wishbone slave: one wait state, unmapped reads give zero
   assign wbReq = wb_cyc_i && wb_stb_i;

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         wb_ack_o    <= 1'h0;
         wb_dat_o    <= 32'h0000_0000;
         softOff_reg <= ucpmc_pkg::CTRL_SOFT_OFF_RESET;
      end else begin
         wb_ack_o <= wbReq && !wb_ack_o;
         if (wbReq && !wb_ack_o) begin
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i == ucpmc_pkg::ADDR_CTRL) begin
               wb_dat_o[ucpmc_pkg::CTRL_SOFT_OFF] <= softOff_reg;
            end else if (wb_adr_i == ucpmc_pkg::ADDR_STATUS) begin
               wb_dat_o[ucpmc_pkg::STAT_PROF_LSB +: 5]  <= portProfile;
               wb_dat_o[ucpmc_pkg::STAT_DISCHARGE]      <= dischargeOn;
               wb_dat_o[ucpmc_pkg::STAT_POWER]          <= powerSwitchOn;
               wb_dat_o[ucpmc_pkg::STAT_DATA]           <= dataSwitchOn;
               wb_dat_o[ucpmc_pkg::STAT_DETECT]         <= chargeDetectOn;
               wb_dat_o[ucpmc_pkg::STAT_CHARGING]       <= indicator_reg;
               wb_dat_o[ucpmc_pkg::STAT_SEL_LSB +: 3]   <= selNow;
               wb_dat_o[ucpmc_pkg::STAT_PIN_LEVEL]      <= syncVec[ucpmc_pkg::SY_PIN];
            end
         end
         if (wbReq && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == ucpmc_pkg::ADDR_CTRL) begin
            softOff_reg <= wb_dat_i[ucpmc_pkg::CTRL_SOFT_OFF];
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence steadySel(logic [2:0] code);
      enabled && !autoMode && selNow == code && !pulseActive && !pulseStart;
   endsequence

   sequence changeSeq;
      selChange && selNow != ucpmc_pkg::SEL_OFF;
   endsequence

   off_disabled_a: assert property (!enabled |=> dischargeOn && !powerSwitchOn && !dataSwitchOn
      && !chargeInd_nOe && portProfile == ucpmc_pkg::PROF_OFF)
      else $error("disabled port not fully off");
   sel_off_a: assert property (enabled && selNow == ucpmc_pkg::SEL_OFF |=> dischargeOn && !powerSwitchOn)
      else $error("select 000 without discharge");
   sdp_mode_a: assert property (steadySel(ucpmc_pkg::SEL_SDP) |=> portProfile == ucpmc_pkg::PROF_SDP
      && dataSwitchOn && !chargeDetectOn)
      else $error("select 110 not standard port");
   cdp_mode_a: assert property (steadySel(ucpmc_pkg::SEL_CDP) |=> portProfile == ucpmc_pkg::PROF_CDP
      && dataSwitchOn && chargeDetectOn)
      else $error("select 111 not charging port");
   div_forced_a: assert property (steadySel(ucpmc_pkg::SEL_DCP_DIV) |=> portProfile == ucpmc_pkg::PROF_DIV
      && !dataSwitchOn)
      else $error("select 101 not divider");
   bc12_forced_a: assert property (steadySel(ucpmc_pkg::SEL_DCP_BC12) |=> portProfile == ucpmc_pkg::PROF_BC12)
      else $error("select 100 not BC1.2");
   skip_pulse_a: assert property (changeSeq and (skipPulse && !pulseActive && !autoPulseReq)
      |=> !pulseActive && !dischargeOn[*2])
      else $error("wakeup change gave a pulse");
   pulse_start_a: assert property (changeSeq and !skipPulse |=> pulseActive && dischargeOn && !powerSwitchOn)
      else $error("mode change without pulse");
   auto_entry_a: assert property (autoPulseReq |=> autoState_reg == ucpmc_pkg::AUTO_PULSE
      ##1 dischargeOn)
      else $error("negotiation did not pulse");
   ind_release_a: assert property (indicator_reg && chargeMode && syncVec[ucpmc_pkg::SY_CUR]
      |=> indicator_reg)
      else $error("indicator dropped while current high");

endmodule : ucpmc_top

//--- verification/ucpmc_host_model.sv
// Host controller model: drives the enable and mode-select pins.
// Assumes the bench posts each request between clock edges.
`timescale 1ns/100ps
module ucpmc_host_model (
   // Clock
   input  wire logic       core_clk,
   // Requests
   input  wire logic [2:0] wantCode,
   input  wire logic       wantEnable,
   // Pins
   output logic            enable,
   output logic            mode_select_bit_one,
   output logic            mode_select_bit_two,
   output logic            mode_select_bit_three
);
   initial begin
      {enable, mode_select_bit_one, mode_select_bit_two, mode_select_bit_three} = 4'h0;
   end
   // All bits move on one edge, so no skewed code is ever shown
   always @(posedge core_clk) begin
      {mode_select_bit_one, mode_select_bit_two, mode_select_bit_three} <= wantCode;
      enable <= wantEnable;
   end
endmodule : ucpmc_host_model

//--- verification/usb_charge_port_mode_controller_tb.sv
// Bench for the charge-port mode controller with short timer parameters.
// Assumes the host model drives the pins and detectors are bench levels.
`timescale 1ns/100ps
module usb_charge_port_mode_controller_tb;
   localparam int P = 20;
   localparam int D = 50;
   localparam int C = 30;
   localparam logic [2:0] CODES [7] = '{3'h6, 3'h7, 3'h2, 3'h3, 3'h1, 3'h5, 3'h4};
   // Expected {profile, data switch, charge detection} per code
   localparam logic [6:0] EXPS [7] = '{7'h0A, 7'h13, 7'h0A, 7'h13, 7'h21, 7'h21, 7'h41};
   logic        core_clk, reset_n, cyc, stb, ack, en, b1, b2, b3, wantEn;
   logic        neg, att, fhs, cur, pw, dsw, dis, det, indOe, hs, we, indOut;
   logic [2:0]  want;
   logic [3:0]  adr;
   logic [31:0] rd, dout, wdat;
   ucpmc_pkg::ucpmc_profile_type prof;
   int          errCount = 0;
   int          checked = 0;
   int          n;

   ucpmc_host_model u_host (.core_clk(core_clk), .wantCode(want), .wantEnable(wantEn), .enable(en),
      .mode_select_bit_one(b1), .mode_select_bit_two(b2), .mode_select_bit_three(b3));
   ucpmc_top #(.PULSE_CYCLES(P), .DETACH_CYCLES(D), .CHG_OFF_CYCLES(C)) u_dut (
      .core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
      .enable(en), .mode_select_bit_one(b1), .mode_select_bit_two(b2), .mode_select_bit_three(b3),
      .chargeNegotiation(neg), .deviceAttached(att), .deviceFullHighSpeed(fhs),
      .currentAboveThreshold(cur), .cdpHandshakeDone(hs), .portProfile(prof), .powerSwitchOn(pw),
      .dataSwitchOn(dsw), .dischargeOn(dis), .chargeDetectOn(det),
      // Open-drain indicator pin with a pull-up when released
      .chargeInd_nIn(indOe ? indOut : 1'b1), .chargeInd_nOut(indOut), .chargeInd_nOe(indOe));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errCount++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
   endtask : tick

   // Waits a bounded time for the discharge output to reach a level
   task automatic waitDis(input logic v, output int k);
      k = 0;
      while (dis !== v) begin
         tick(1);
         k++;
         if (k > 200) begin
            errCount++;
            conclude();
         end
      end
   endtask : waitDis

   task automatic noPulse(input logic [2:0] c);
      logic seen;
      seen = 1'b0;
      want <= c;
      repeat (P + 12) begin
         tick(1);
         seen = seen | dis | ~dsw;
      end
      chk(seen, 1'b0);
   endtask : noPulse

   task automatic wbCycle(input logic w, input logic [3:0] a, input logic [31:0] d);
      int i;
      i = 0;
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
      do begin
         tick(1);
         i++;
      end while (ack !== 1'b1 && i < 20);
      if (ack !== 1'b1) begin
         errCount++;
         conclude();
      end
      rd = dout;
      {cyc, stb, we} <= 3'b000;
      tick(1);
   endtask : wbCycle

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      {reset_n, cyc, stb, we, adr, wdat, want, neg, att, fhs, cur, hs} = '0;
      wantEn = 1'b1;
      tick(12);
      reset_n <= 1'b1;
      tick(6);
      chk({prof, dis, pw}, {ucpmc_pkg::PROF_OFF, 2'b10});
      for (int i = 0; i < 7; i++) begin
         want <= CODES[i];
         tick(P + 12);
         chk({prof, dsw, det, dis, pw}, {EXPS[i], 2'b01});
      end
      want <= 3'h6;
      tick(P + 12);
      noPulse(3'h2);
      noPulse(3'h6);
      noPulse(3'h3);
      noPulse(3'h7);
      noPulse(3'h3);
      {att, fhs} <= 2'b11;
      tick(P + 12);
      chk(prof, ucpmc_pkg::PROF_DIV);
      {att, fhs} <= 2'b00;
      want <= 3'h1;
      tick(P + 12);
      {att, neg} <= 2'b11;
      waitDis(1'b1, n);
      waitDis(1'b0, n);
      tick(2);
      chk({prof, 1'b1}, {ucpmc_pkg::PROF_BC12, n >= P - 1 && n <= P + 1});
      {att, neg} <= 2'b00;
      for (n = 0; prof !== ucpmc_pkg::PROF_DIV && n < 200; n++) tick(1);
      chk(n >= D && n <= D + 6, 1'b1);
      want <= 3'h5;
      tick(P + 12);
      cur <= 1'b1;
      tick(5);
      chk(indOe, 1'b1);
      wbCycle(1'b0, 4'h4, 32'h0000_0000);
      chk({rd[13], rd[9]}, 2'b01);
      cur <= 1'b0;
      tick(C - 2);
      chk(indOe, 1'b1);
      tick(12);
      chk(indOe, 1'b0);
      want <= 3'h7;
      tick(P + 12);
      cur <= 1'b1;
      tick(5);
      chk(indOe, 1'b0);
      {cur, hs} <= 2'b01;
      tick(4);
      cur <= 1'b1;
      tick(5);
      chk(indOe, 1'b1);
      {cur, hs, want} <= {2'b00, 3'h6};
      waitDis(1'b1, n);
      waitDis(1'b0, n);
      chk(n >= P - 1 && n <= P + 1, 1'b1);
      wbCycle(1'b1, 4'h0, 32'h0000_0001);
      wbCycle(1'b0, 4'h0, 32'h0000_0000);
      chk({prof, pw, dsw, dis, rd[0]}, {ucpmc_pkg::PROF_OFF, 4'h3});
      wbCycle(1'b1, 4'h0, 32'h0000_0000);
      wantEn <= 1'b0;
      cur <= 1'b1;
      tick(6);
      chk({prof, pw, dsw, dis, indOe}, {ucpmc_pkg::PROF_OFF, 4'h2});
      wbCycle(1'b0, 4'h4, 32'h0000_0000);
      chk({rd[13], rd[5:0]}, 7'h61);
      wbCycle(1'b0, 4'h8, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      conclude();
   end
endmodule : usb_charge_port_mode_controller_tb
